// ---- scsf_pkg.sv ----
// Package for the smart card status flag block: register map, field positions,
// reset values and the packed structs that carry state and receive events.
// Assumes a 32-bit APB register bus and one 25 MHz clock.
package scsf_pkg;

  // Register byte addresses
  localparam logic [7:0] SCSF_STATUS_OFS = 8'h00;
  localparam logic [7:0] SCSF_CTRL_OFS = 8'h04;
  localparam logic [7:0] SCSF_MODE_OFS = 8'h08;
  localparam logic [7:0] SCSF_TXDATA_OFS = 8'h0c;
  localparam logic [7:0] SCSF_RXDATA_OFS = 8'h10;

  // Status bit positions
  localparam int unsigned SCSF_TX_EMPTY_BIT = 7;
  localparam int unsigned SCSF_RX_FULL_BIT = 6;
  localparam int unsigned SCSF_OVERRUN_BIT = 5;
  localparam int unsigned SCSF_ERR_SIG_BIT = 4;

  // Control and mode bit positions
  localparam int unsigned SCSF_TX_ON_BIT = 5;
  localparam int unsigned SCSF_RX_ON_BIT = 4;
  localparam int unsigned SCSF_SC_SEL_BIT = 0;

  // Flag index inside the arm vector
  localparam int unsigned SCSF_IX_ERR_SIG = 0;
  localparam int unsigned SCSF_IX_OVERRUN = 1;
  localparam int unsigned SCSF_IX_RX_FULL = 2;
  localparam int unsigned SCSF_IX_TX_EMPTY = 3;

  // Reset values and transmit buffer depth
  localparam logic SCSF_TX_EMPTY_RST = 1'b1;
  localparam logic SCSF_RX_FULL_RST = 1'b0;
  localparam logic SCSF_OVERRUN_RST = 1'b0;
  localparam logic SCSF_ERR_SIG_RST = 1'b0;
  localparam logic SCSF_BIT_RST = 1'b0;
  localparam logic [3:0] SCSF_ARM_RST = 4'h0;
  localparam logic [31:0] SCSF_WORD_RST = 32'h0000_0000;
  localparam logic [7:0] SCSF_DATA_RST = 8'h00;
  localparam logic [1:0] SCSF_CNT_RST = 2'h0;
  localparam logic [1:0] SCSF_BUF_DEPTH = 2'h2;

  // One received character as handed over by the receiver
  typedef struct packed {
    logic done;
    logic ok;
    logic err_low;
    logic [7:0] data;
  } scsf_rx_evt_t;

  // Whole state of the block
  typedef struct packed {
    logic transmit_buffer_empty_flag;
    logic receive_buffer_full_flag;
    logic overrun_flag;
    logic error_signal_flag;
    logic [3:0] armed;
    logic ack;
    logic transmit_enable_bit;
    logic rx_on_bit;
    logic smartcard_select_bit;
    logic [7:0] transmit_holding_reg;
    logic [7:0] receive_holding_reg;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic [1:0] cnt;
    logic [31:0] prdata;
  } scsf_state_t;

endpackage : scsf_pkg

// ---- scsf_top.sv ----
// Status flag logic of a serial unit in smart card mode, with APB registers,
// a transmit holding register feeding a two-entry buffer, and a receive holding register.
// Assumes an APB master that waits for pready, a serializer that drains tx_data by valid/ready,
// and a receiver that delivers each completed character as a one-cycle event.
//
// Notes on behaviour
// - Flag behaviour applies only while smartcard select bit is 1, except the empty flag hold while transmit enable is 0.
// - Transmit buffer empty flag at status bit 7 reads 1 after reset.
// - Transmit buffer empty flag held at 1 while transmit enable is 0.
// - Moving holding byte into shift path sets transmit buffer empty flag.
// - Software write of 0 after reading 1 clears transmit buffer empty flag.
// - Controller write of transmit data on tx request clears transmit empty flag.
// - Receive full flag, bit 6, resets 0; set on clean reception into holding.
// - Software write of 0 after reading 1 clears receive full flag.
// - Controller read of receive data on rx request clears receive full flag.
// - Clearing the receive enable bit leaves the receive full flag unchanged.
// - Overrun, bit 5, resets 0; set when receiving while full; new byte dropped.
// - No further reception while the overrun flag is 1.
// - Overrun flag clears only by software write of 0 after reading 1.
// - Clearing the receive enable bit leaves the overrun flag unchanged.
// - Error signal flag, bit 4, resets 0; set when low error signal sampled.
// - Software write of 0 after reading 1 clears the error signal flag.
// - Writing 1 to a flag leaves it unchanged; only 0 can clear.
`timescale 1ns/100ps

module scsf_top
  import scsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer requests toward the DMA or transfer controller
  output logic tx_ready_irq,
  output logic rx_full_irq,
  input wire logic dma_tx_wr,
  input wire logic [7:0] dma_tx_data,
  input wire logic dma_rx_rd,
  output logic [7:0] rx_hold_data,
  // Transmit stream toward the serializer
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Receive events from the deserializer
  input wire scsf_rx_evt_t rx_evt,
  output logic rx_accept
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  scsf_state_t state_ff;
  scsf_state_t nxt_state;

  logic access;
  logic rd_first;
  logic wr_done;
  logic rd_done;
  logic addr_hit;
  logic [31:0] rd_word;
  logic [3:0] flag_vec;
  logic [3:0] seen_vec;
  logic [3:0] sw_clear;
  logic push;
  logic pop;
  logic rx_take;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // One wait state: read data is registered in the first access cycle,
  // so it already stands when pready is high in the second
  assign access = psel && penable;
  assign rd_first = access && !pwrite && !state_ff.ack;
  assign wr_done = access && pwrite && state_ff.ack;
  assign rd_done = access && !pwrite && state_ff.ack;

  always_comb
  begin
    addr_hit = 1'b1;
    rd_word = SCSF_WORD_RST;
    case (paddr)
      SCSF_STATUS_OFS:
      begin
        rd_word[SCSF_TX_EMPTY_BIT] = state_ff.transmit_buffer_empty_flag;
        rd_word[SCSF_RX_FULL_BIT] = state_ff.receive_buffer_full_flag;
        rd_word[SCSF_OVERRUN_BIT] = state_ff.overrun_flag;
        rd_word[SCSF_ERR_SIG_BIT] = state_ff.error_signal_flag;
      end
      SCSF_CTRL_OFS:
      begin
        rd_word[SCSF_TX_ON_BIT] = state_ff.transmit_enable_bit;
        rd_word[SCSF_RX_ON_BIT] = state_ff.rx_on_bit;
      end
      SCSF_MODE_OFS:
      begin
        rd_word[SCSF_SC_SEL_BIT] = state_ff.smartcard_select_bit;
      end
      SCSF_TXDATA_OFS:
      begin
        rd_word[7:0] = state_ff.transmit_holding_reg;
      end
      SCSF_RXDATA_OFS:
      begin
        rd_word[7:0] = state_ff.receive_holding_reg;
      end
      default:
      begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Unmapped addresses answer with an error
  assign pready = state_ff.ack;
  assign pslverr = access && !addr_hit;
  assign prdata = state_ff.prdata;

  ////////////////////////////////////////////////////////////////////////////
  // Flag clear by software

  assign flag_vec = {state_ff.transmit_buffer_empty_flag, state_ff.receive_buffer_full_flag,
                     state_ff.overrun_flag, state_ff.error_signal_flag};

  // Flags as software saw them in the word of the current status read
  assign seen_vec = {state_ff.prdata[SCSF_TX_EMPTY_BIT], state_ff.prdata[SCSF_RX_FULL_BIT],
                     state_ff.prdata[SCSF_OVERRUN_BIT], state_ff.prdata[SCSF_ERR_SIG_BIT]};

  // Software clears a flag only with a 0 written after an armed read; a 1 is ignored
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_clr
      assign sw_clear[gi] = wr_done && (paddr == SCSF_STATUS_OFS) && state_ff.armed[gi]
                            && !pwdata[SCSF_ERR_SIG_BIT + gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data path handshakes

  // Holding register moves on once software or the controller has filled it
  assign push = state_ff.smartcard_select_bit && state_ff.transmit_enable_bit
                && !state_ff.transmit_buffer_empty_flag && (state_ff.cnt != SCSF_BUF_DEPTH);
  assign tx_valid = (state_ff.cnt != SCSF_CNT_RST);
  assign tx_data = state_ff.buf0;
  assign pop = tx_valid && tx_ready;

  // Receiver is refused while overrun stands or the mode is off
  assign rx_accept = state_ff.smartcard_select_bit && state_ff.rx_on_bit && !state_ff.overrun_flag;
  assign rx_take = rx_evt.done && rx_accept;

  assign tx_ready_irq = state_ff.smartcard_select_bit && state_ff.transmit_enable_bit
                        && state_ff.transmit_buffer_empty_flag;
  assign rx_full_irq = state_ff.smartcard_select_bit && state_ff.receive_buffer_full_flag;
  assign rx_hold_data = state_ff.receive_holding_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_state = state_ff;

    // Wait state ends every access; writes and arming act at that edge only
    nxt_state.ack = access && !state_ff.ack;

    // Read data is registered in the first access cycle
    if (rd_first)
    begin
      nxt_state.prdata = rd_word;
    end

    // Control and mode registers
    if (wr_done && (paddr == SCSF_CTRL_OFS))
    begin
      nxt_state.transmit_enable_bit = pwdata[SCSF_TX_ON_BIT];
      nxt_state.rx_on_bit = pwdata[SCSF_RX_ON_BIT];
    end
    if (wr_done && (paddr == SCSF_MODE_OFS))
    begin
      nxt_state.smartcard_select_bit = pwdata[SCSF_SC_SEL_BIT];
    end

    // Transmit holding register, by software or controller
    if (wr_done && (paddr == SCSF_TXDATA_OFS))
    begin
      nxt_state.transmit_holding_reg = pwdata[7:0];
    end
    if (dma_tx_wr && state_ff.smartcard_select_bit)
    begin
      nxt_state.transmit_holding_reg = dma_tx_data;
    end

    // Two-entry transmit buffer
    case ({push, pop})
      2'b10:
      begin
        if (state_ff.cnt == SCSF_CNT_RST)
        begin
          nxt_state.buf0 = state_ff.transmit_holding_reg;
        end
        else
        begin
          nxt_state.buf1 = state_ff.transmit_holding_reg;
        end
        nxt_state.cnt = state_ff.cnt + 2'h1;
      end
      2'b01:
      begin
        nxt_state.buf0 = state_ff.buf1;
        nxt_state.cnt = state_ff.cnt - 2'h1;
      end
      2'b11:
      begin
        if (state_ff.cnt == 2'h1)
        begin
          nxt_state.buf0 = state_ff.transmit_holding_reg;
        end
        else
        begin
          nxt_state.buf0 = state_ff.buf1;
          nxt_state.buf1 = state_ff.transmit_holding_reg;
        end
      end
      default:
      begin
        nxt_state.cnt = state_ff.cnt;
      end
    endcase

    // Transmit buffer empty flag: clears first, sets win
    if (state_ff.smartcard_select_bit)
    begin
      if (sw_clear[SCSF_IX_TX_EMPTY])
      begin
        nxt_state.transmit_buffer_empty_flag = 1'b0;
      end
      if (dma_tx_wr)
      begin
        nxt_state.transmit_buffer_empty_flag = 1'b0;
      end
      if (push)
      begin
        nxt_state.transmit_buffer_empty_flag = 1'b1;
      end
    end
    if (!state_ff.transmit_enable_bit)
    begin
      nxt_state.transmit_buffer_empty_flag = 1'b1;
    end

    // Receive side flags
    if (state_ff.smartcard_select_bit)
    begin
      if (sw_clear[SCSF_IX_RX_FULL])
      begin
        nxt_state.receive_buffer_full_flag = 1'b0;
      end
      if (dma_rx_rd)
      begin
        nxt_state.receive_buffer_full_flag = 1'b0;
      end
      if (sw_clear[SCSF_IX_OVERRUN])
      begin
        nxt_state.overrun_flag = 1'b0;
      end
      if (sw_clear[SCSF_IX_ERR_SIG])
      begin
        nxt_state.error_signal_flag = 1'b0;
      end

      // Overrun is judged on the flag as it stood, so a same-cycle
      // clear does not rescue the incoming byte
      if (rx_take && rx_evt.ok)
      begin
        if (state_ff.receive_buffer_full_flag)
        begin
          nxt_state.overrun_flag = 1'b1;
        end
        else
        begin
          nxt_state.receive_holding_reg = rx_evt.data;
          nxt_state.receive_buffer_full_flag = 1'b1;
        end
      end

      // Error signal is sampled whatever the receive state
      if (rx_evt.err_low)
      begin
        nxt_state.error_signal_flag = 1'b1;
      end
    end

    // Arming: a status read remembers which flags it returned as 1;
    // a flag that dropped during the wait state is not armed
    if (rd_done && (paddr == SCSF_STATUS_OFS))
    begin
      nxt_state.armed = seen_vec & flag_vec;
    end
    else if (wr_done && (paddr == SCSF_STATUS_OFS))
    begin
      nxt_state.armed = SCSF_ARM_RST;
    end
    else
    begin
      nxt_state.armed = state_ff.armed & flag_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff.transmit_buffer_empty_flag <= SCSF_TX_EMPTY_RST;
      state_ff.receive_buffer_full_flag <= SCSF_RX_FULL_RST;
      state_ff.overrun_flag <= SCSF_OVERRUN_RST;
      state_ff.error_signal_flag <= SCSF_ERR_SIG_RST;
      state_ff.armed <= SCSF_ARM_RST;
      state_ff.ack <= SCSF_BIT_RST;
      state_ff.transmit_enable_bit <= SCSF_BIT_RST;
      state_ff.rx_on_bit <= SCSF_BIT_RST;
      state_ff.smartcard_select_bit <= SCSF_BIT_RST;
      state_ff.transmit_holding_reg <= SCSF_DATA_RST;
      state_ff.receive_holding_reg <= SCSF_DATA_RST;
      state_ff.buf0 <= SCSF_DATA_RST;
      state_ff.buf1 <= SCSF_DATA_RST;
      state_ff.cnt <= SCSF_CNT_RST;
      state_ff.prdata <= SCSF_WORD_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

endmodule : scsf_top

// ---- scsf_chk.sv ----
// Port-level checker for scsf_top, attached by bind.
// Sees only top-level ports; one clock domain.
`timescale 1ns/100ps
module scsf_chk
  import scsf_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  // Requests and streams
  input wire logic tx_ready_irq,
  input wire logic rx_full_irq,
  input wire logic dma_tx_wr,
  input wire logic [7:0] dma_tx_data,
  input wire logic dma_rx_rd,
  input wire logic [7:0] rx_hold_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire scsf_rx_evt_t rx_evt,
  input wire logic rx_accept
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rx_take;
  assign rx_take = rx_evt.done && rx_evt.ok && rx_accept;
  ////////////////////////////////////////////////////////////////
  property p_bad_addr; psel && penable && paddr > 8'h10 |-> pslverr; endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("no pslverr on unmapped access");
  property p_rx_set; rx_take && !rx_full_irq |=> rx_full_irq && rx_hold_data == $past(rx_evt.data); endproperty
  a_rx_set: assert property (p_rx_set) else $error("clean byte not stored");
  property p_ovr_keep; rx_take && rx_full_irq |=> $stable(rx_hold_data); endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun byte overwrote holding");
  property p_ovr_stop; rx_take && rx_full_irq |=> !rx_accept [*3]; endproperty
  a_ovr_stop: assert property (p_ovr_stop) else $error("reception open after overrun");
  property p_dma_rd; dma_rx_rd && rx_full_irq && !rx_take |=> !rx_full_irq; endproperty
  a_dma_rd: assert property (p_dma_rd) else $error("controller read left full flag");
  property p_dma_wr; dma_tx_wr && tx_ready_irq |=> !tx_ready_irq; endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("controller write left empty flag");
  property p_move; dma_tx_wr && tx_ready_irq && !tx_valid |=> ##1 tx_valid && tx_ready_irq && tx_data == $past(dma_tx_data, 2); endproperty
  a_move: assert property (p_move) else $error("holding byte not moved");
  property p_off; rx_evt.done && !rx_accept |=> $stable(rx_hold_data); endproperty
  a_off: assert property (p_off) else $error("refused event changed holding");
  c_ovr: cover property (rx_take && rx_full_irq);
  c_dma: cover property (dma_tx_wr && tx_ready_irq);
  c_bad: cover property (pslverr);
endmodule : scsf_chk

bind scsf_top scsf_chk u_scsf_chk (.clk, .rst_n, .psel, .penable, .paddr, .pslverr, .tx_ready_irq, .rx_full_irq,
  .dma_tx_wr, .dma_tx_data, .dma_rx_rd, .rx_hold_data, .tx_valid, .tx_data, .rx_evt, .rx_accept);

// ---- scsf_card.sv ----
// Card-side model: drains the transmit stream, delivers receive events.
// Bench steers it through stall and the send task.
`timescale 1ns/100ps
module scsf_card
  import scsf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Receive side
  input wire logic stall,
  output scsf_rx_evt_t rx_evt
);
  logic [7:0] got [$];
  initial rx_evt = '0;
  assign tx_ready = !stall;
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  // Idle data inverted so a stale byte never looks fresh
  task send(input logic ok, input logic er, input logic [7:0] d);
    rx_evt <= '{1'b1, ok, er, d};
    @(posedge clk);
    rx_evt <= '{1'b0, 1'b0, 1'b0, ~d};
    @(posedge clk);
  endtask : send
endmodule : scsf_card

// ---- scsf_bench.sv ----
// Self-checking bench for scsf_top: APB master plus card model.
// Assumes an APB slave that may insert wait states before pready.
`timescale 1ns/100ps
module scsf_bench
  import scsf_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
  logic dma_tx_wr = 1'b0, dma_rx_rd = 1'b0;
  logic [7:0] paddr = 8'h00, dma_tx_data = 8'h00, rx_hold_data, tx_data;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, tx_ready_irq, rx_full_irq, rx_accept, tx_valid, tx_ready;
  scsf_rx_evt_t rx_evt;
  int n_errors = 0, check_count = 0, cyc = 0;
  always #20 clk = ~clk;
  scsf_top u_scsf_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_ready_irq, .rx_full_irq, .dma_tx_wr, .dma_tx_data, .dma_rx_rd, .rx_hold_data, .tx_valid, .tx_ready,
    .tx_data, .rx_evt, .rx_accept);
  scsf_card u_scsf_card (.clk, .tx_valid, .tx_data, .tx_ready, .stall, .rx_evt);
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Idle cycle between transfers keeps one assignment per time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdv = prdata;
    chk("pslverr", {31'h0, a > 8'h10}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task st(input logic [31:0] e);
    apb(1'b0, SCSF_STATUS_OFS, 32'h0);
    chk("status", e, rdv);
  endtask : st
  // Controller writes only while the transmit request stands
  task dma_wr(input logic [7:0] d);
    while (tx_ready_irq !== 1'b1)
      @(posedge clk);
    dma_tx_wr <= 1'b1;
    dma_tx_data <= d;
    @(posedge clk);
    dma_tx_wr <= 1'b0;
    @(posedge clk);
  endtask : dma_wr
  ////////////////////////////////////////////////////////////////
  task t_reset;
    st(32'h80);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rdv);
    u_scsf_card.send(1'b1, 1'b1, 8'h5a);
    st(32'h80);
  endtask : t_reset
  task t_sw_tx;
    apb(1'b1, SCSF_MODE_OFS, 32'h1);
    apb(1'b1, SCSF_CTRL_OFS, 32'h30);
    apb(1'b1, SCSF_TXDATA_OFS, 32'ha5);
    apb(1'b1, SCSF_STATUS_OFS, 32'hff);
    apb(1'b1, SCSF_STATUS_OFS, 32'h0);
    chk("sent", 32'h0, u_scsf_card.got.size());
    st(32'h80);
    apb(1'b1, SCSF_STATUS_OFS, 32'h0);
    st(32'h80);
    chk("byte", 32'ha5, {24'h0, u_scsf_card.got.pop_front()});
    chk("tx irq", 32'h1, {31'h0, tx_ready_irq});
  endtask : t_sw_tx
  // Card stalls so the buffer fills and holds the empty flag low
  task t_fill;
    stall <= 1'b1;
    dma_wr(8'h11);
    dma_wr(8'h22);
    dma_wr(8'h33);
    chk("tx irq", 32'h0, {31'h0, tx_ready_irq});
    apb(1'b1, SCSF_CTRL_OFS, 32'h10);
    st(32'h80);
    apb(1'b1, SCSF_CTRL_OFS, 32'h30);
    stall <= 1'b0;
    for (int i = 0; i < 8 && tx_valid !== 1'b0; i++)
      @(posedge clk);
    chk("sent", 32'h2, u_scsf_card.got.size());
    chk("byte", 32'h11, {24'h0, u_scsf_card.got.pop_front()});
    chk("byte", 32'h22, {24'h0, u_scsf_card.got.pop_front()});
  endtask : t_fill
  task t_rx;
    u_scsf_card.send(1'b1, 1'b0, 8'h3c);
    chk("hold", 32'h3c, {24'h0, rx_hold_data});
    u_scsf_card.send(1'b1, 1'b0, 8'h55);
    chk("hold", 32'h3c, {24'h0, rx_hold_data});
    chk("accept", 32'h0, {31'h0, rx_accept});
    apb(1'b1, SCSF_CTRL_OFS, 32'h20);
    st(32'he0);
    apb(1'b1, SCSF_STATUS_OFS, 32'h9f);
    st(32'h80);
    apb(1'b1, SCSF_CTRL_OFS, 32'h30);
  endtask : t_rx
  task t_ers;
    u_scsf_card.send(1'b0, 1'b1, 8'h77);
    st(32'h90);
    apb(1'b1, SCSF_STATUS_OFS, 32'hef);
    st(32'h80);
  endtask : t_ers
  task t_dma_rx;
    u_scsf_card.send(1'b1, 1'b0, 8'hc3);
    chk("rx irq", 32'h1, {31'h0, rx_full_irq});
    chk("hold", 32'hc3, {24'h0, rx_hold_data});
    dma_rx_rd <= 1'b1;
    @(posedge clk);
    dma_rx_rd <= 1'b0;
    @(posedge clk);
    chk("rx irq", 32'h0, {31'h0, rx_full_irq});
  endtask : t_dma_rx
  ////////////////////////////////////////////////////////////////
  task final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      final_report;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_sw_tx;
    t_fill;
    t_rx;
    t_ers;
    t_dma_rx;
    final_report;
  end
endmodule : scsf_bench
